// ===== pkg/gio_pkg.sv
package gio_pkg;

  // ----------------------------------------------------------------
  // configuration byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] GIO_ADDR_EVENT_PINS = 8'h0E;
  localparam logic [7:0] GIO_ADDR_IRQ_DIR    = 8'h0F;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int GIO_USER_LSB      = 3;
  localparam int GIO_USER_MSB      = 7;
  localparam int GIO_PIN_LSB       = 0;
  localparam int GIO_PIN_MSB       = 2;
  localparam int GIO_IRQ_IGN_BIT   = 7;
  localparam int GIO_RSVD0_BIT     = 6;
  localparam int GIO_REASON_BIT    = 5;
  localparam int GIO_SPEED_EN_BIT  = 4;
  localparam int GIO_RSVD1_BIT     = 3;
  localparam int GIO_SPEED_PIN     = 2;

  // ----------------------------------------------------------------
  // reset values and unmapped read value
  // ----------------------------------------------------------------
  localparam logic [7:0] GIO_RST_EVENT_PINS = 8'h00;
  localparam logic [7:0] GIO_RST_IRQ_DIR    = 8'h07;
  localparam logic [7:0] GIO_RD_UNMAPPED    = 8'h00;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } gio_cfg_req_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } gio_cfg_rsp_t;

endpackage : gio_pkg

// ===== core/gio_option_config.sv
`timescale 1ns/1ns
// Behaviour
// - user event bits from user_event_and_pin_values bits 7:3
// - output pins driven to written bit level
// - user_event_and_pin_values read returns sampled pin levels
// - ata_irq_and_pin_direction bit7 set ignores storage irq line
// - ata_irq_and_pin_direction bit5 set ignores interrupt reason
// - ata_irq_and_pin_direction bit4 makes pin2 speed indicator
// - direction bits: zero drives, one floats
// - direction bit overrides speed indicator
module gio_option_config
  import gio_pkg::*;
#(
  parameter int PINS = 3
)(
  input  wire logic                  i_clk,
  input  wire logic                  i_reset_n,
  input  wire gio_pkg::gio_cfg_req_t i_cfg_req,
  output gio_pkg::gio_cfg_rsp_t      o_cfg_rsp,
  input  wire logic [PINS-1:0]       i_gpio_in,
  output logic [PINS-1:0]            o_gpio_out,
  output logic [PINS-1:0]            o_gpio_oe,
  input  wire logic                  i_high_speed,
  input  wire logic                  i_storage_irq_line,
  output logic                       o_storage_irq_line,
  output logic [4:0]                 o_user_event_bits,
  output logic                       o_packet_irq_ignore,
  output logic                       o_int_reason_ignore
);
  import gio_pkg::*;

  // ----------------------------------------------------------------
  // parameter check
  // ----------------------------------------------------------------
  generate
    if (PINS != 3)
    begin : g_bad_pins
      $error("gio_option_config: PINS must be 3");
    end
  endgenerate

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_r;
  logic       rst_n;

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      rst_sync_r <= 2'h0;
    else
      rst_sync_r <= {rst_sync_r[0], 1'b1};
  end

  assign rst_n = rst_sync_r[1];

  // ----------------------------------------------------------------
  // configuration bytes
  // ----------------------------------------------------------------
  logic [7:0] event_pins_r;
  logic [7:0] irq_dir_r;

  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
      event_pins_r <= GIO_RST_EVENT_PINS;
    else if (i_cfg_req.wr && i_cfg_req.addr == GIO_ADDR_EVENT_PINS)
      event_pins_r <= i_cfg_req.wdata;
  end

  // reserved bits stored as written; source keeps them
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
      irq_dir_r <= GIO_RST_IRQ_DIR;
    else if (i_cfg_req.wr && i_cfg_req.addr == GIO_ADDR_IRQ_DIR)
      irq_dir_r <= i_cfg_req.wdata;
  end

  // ----------------------------------------------------------------
  // pin input synchronisers
  // ----------------------------------------------------------------
  logic [PINS-1:0] pin_s1_r;
  logic [PINS-1:0] pin_s2_r;
  logic [PINS-1:0] pin_s3_r;
  logic [PINS-1:0] pin_lvl_r;

  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
      pin_s3_r <= '0;
    end
    else
    begin
      pin_s1_r <= i_gpio_in;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
    end
  end

  generate
    for (genvar g = 0; g < PINS; g++)
    begin : g_pin
      always_ff @(posedge i_clk or negedge rst_n)
      begin
        if (!rst_n)
          pin_lvl_r[g] <= 1'b0;
        else if (pin_s2_r[g] == pin_s3_r[g])
          pin_lvl_r[g] <= pin_s3_r[g];
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // pin drivers
  // ----------------------------------------------------------------
  logic [PINS-1:0] out_nxt;
  logic            speed_mode;

  // direction bit gates the driver, so it wins over the indicator
  assign speed_mode = irq_dir_r[GIO_SPEED_EN_BIT];

  always_comb
  begin
    out_nxt = event_pins_r[GIO_PIN_MSB:GIO_PIN_LSB];
    if (speed_mode)
      out_nxt[GIO_SPEED_PIN] = ~i_high_speed;
  end

  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
      o_gpio_out <= '0;
    else
      o_gpio_out <= out_nxt;
  end

  // ----------------------------------------------------------------
  // pin enables
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
      o_gpio_oe <= '0;
    else
      o_gpio_oe <= ~irq_dir_r[GIO_PIN_MSB:GIO_PIN_LSB];
  end

  // ----------------------------------------------------------------
  // option outputs
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
      o_user_event_bits <= '0;
    else
      o_user_event_bits <= event_pins_r[GIO_USER_MSB:GIO_USER_LSB];
  end

  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_packet_irq_ignore <= 1'b0;
      o_int_reason_ignore <= 1'b0;
    end
    else
    begin
      o_packet_irq_ignore <= irq_dir_r[GIO_IRQ_IGN_BIT];
      o_int_reason_ignore <= irq_dir_r[GIO_REASON_BIT];
    end
  end

  // ----------------------------------------------------------------
  // storage irq gate
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
      o_storage_irq_line <= 1'b0;
    else
      o_storage_irq_line <= i_storage_irq_line &
                            ~irq_dir_r[GIO_IRQ_IGN_BIT];
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  logic [7:0] rdata_nxt;

  always_comb
  begin
    unique case (i_cfg_req.addr)
      GIO_ADDR_EVENT_PINS:
        rdata_nxt = {event_pins_r[GIO_USER_MSB:GIO_USER_LSB],
                     pin_lvl_r};
      GIO_ADDR_IRQ_DIR:
        rdata_nxt = irq_dir_r;
      default:
        rdata_nxt = GIO_RD_UNMAPPED;
    endcase
  end

  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
      o_cfg_rsp <= '0;
    else
    begin
      o_cfg_rsp.valid <= i_cfg_req.rd;
      o_cfg_rsp.data  <= i_cfg_req.rd ? rdata_nxt : o_cfg_rsp.data;
    end
  end

endmodule : gio_option_config

// ===== verif/gio_option_config_props.sv
`timescale 1ns/1ns
module gio_option_config_props
  import gio_pkg::*;
(
  input wire logic                  i_clk,
  input wire logic                  i_reset_n,
  input wire gio_pkg::gio_cfg_req_t i_cfg_req,
  input wire gio_pkg::gio_cfg_rsp_t o_cfg_rsp,
  input wire logic [2:0]            i_gpio_in,
  input wire logic [2:0]            o_gpio_out,
  input wire logic [2:0]            o_gpio_oe,
  input wire logic                  i_high_speed,
  input wire logic                  i_storage_irq_line,
  input wire logic                  o_storage_irq_line,
  input wire logic [4:0]            o_user_event_bits,
  input wire logic                  o_packet_irq_ignore,
  input wire logic                  o_int_reason_ignore
);
  // ----
  // checks
  // ----
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  logic we;
  logic wf;
  logic re;
  assign we = i_cfg_req.wr && i_cfg_req.addr == GIO_ADDR_EVENT_PINS;
  assign wf = i_cfg_req.wr && i_cfg_req.addr == GIO_ADDR_IRQ_DIR;
  assign re = i_cfg_req.rd && i_cfg_req.addr == GIO_ADDR_EVENT_PINS;
  pin_value_a: assert property (
    we |-> ##2 o_gpio_out[1:0] == $past(i_cfg_req.wdata[1:0], 2))
    else $error("pin output value wrong");
  user_bits_a: assert property (
    we |-> ##2 o_user_event_bits == $past(i_cfg_req.wdata[7:3], 2))
    else $error("user event bits wrong");
  dir_enable_a: assert property (
    wf |-> ##2 o_gpio_oe == ~$past(i_cfg_req.wdata[2:0], 2))
    else $error("pin enable wrong");
  irq_options_a: assert property (
    wf |-> ##2 o_packet_irq_ignore == $past(i_cfg_req.wdata[7], 2)
    && o_int_reason_ignore == $past(i_cfg_req.wdata[5], 2))
    else $error("option flags wrong");
  rsp_pulse_a: assert property (
    1'b1 |=> o_cfg_rsp.valid == $past(i_cfg_req.rd))
    else $error("read answer timing wrong");
  irq_gate_a: assert property (
    $past(i_reset_n) && $past(i_reset_n, 2) && $past(i_reset_n, 3)
    |-> o_storage_irq_line ==
        ($past(i_storage_irq_line) && !o_packet_irq_ignore))
    else $error("storage irq gating wrong");
  speed_pin_a: assert property (
    wf && i_cfg_req.wdata[4] ##1 !wf
    |=> o_gpio_out[2] == !$past(i_high_speed))
    else $error("speed indicator level wrong");
  read_back_a: assert property (
    wf ##1 !i_cfg_req.wr ##1 (i_cfg_req.rd && i_cfg_req.addr == 8'h0F)
    |=> o_cfg_rsp.data == $past(i_cfg_req.wdata, 3))
    else $error("direction byte read back wrong");
  unmapped_zero_a: assert property (
    i_cfg_req.rd && i_cfg_req.addr[7:1] != 7'h07 |=> o_cfg_rsp.data == 8'h00)
    else $error("unmapped read not zero");
  pin_sample_a: assert property (
    $stable(i_gpio_in)[*8] ##0 re |=> o_cfg_rsp.data[2:0] == $past(i_gpio_in))
    else $error("pin level read wrong");
endmodule : gio_option_config_props

bind gio_option_config gio_option_config_props gio_option_config_props_i (
  .i_clk(i_clk), .i_reset_n(i_reset_n), .i_cfg_req(i_cfg_req),
  .o_cfg_rsp(o_cfg_rsp), .i_gpio_in(i_gpio_in), .o_gpio_out(o_gpio_out),
  .o_gpio_oe(o_gpio_oe), .i_high_speed(i_high_speed),
  .i_storage_irq_line(i_storage_irq_line),
  .o_storage_irq_line(o_storage_irq_line),
  .o_user_event_bits(o_user_event_bits),
  .o_packet_irq_ignore(o_packet_irq_ignore),
  .o_int_reason_ignore(o_int_reason_ignore));

// ===== verif/gio_pin_model.sv
`timescale 1ns/1ns
module gio_pin_model (
  input  wire logic [2:0] i_out,
  input  wire logic [2:0] i_oe,
  input  wire logic [2:0] i_board,
  output logic [2:0]      o_pin
);
  // board drives released pins only
  assign o_pin = (i_oe & i_out) | (~i_oe & i_board);
endmodule : gio_pin_model

// ===== verif/gio_option_config_bench.sv
`timescale 1ns/1ns
module gio_option_config_bench;
  import gio_pkg::*;
  logic clk, rst_n, hs, irq, irq_o, pkt, rsn;
  logic [2:0] pin, out, oe, brd;
  logic [4:0] usr;
  gio_cfg_req_t req;
  gio_cfg_rsp_t rsp;
  int miscompares, checks_done;
  gio_option_config gio_option_config_i (.i_clk(clk), .i_reset_n(rst_n),
    .i_cfg_req(req), .o_cfg_rsp(rsp), .i_gpio_in(pin), .o_gpio_out(out),
    .o_gpio_oe(oe), .i_high_speed(hs), .i_storage_irq_line(irq),
    .o_storage_irq_line(irq_o), .o_user_event_bits(usr),
    .o_packet_irq_ignore(pkt), .o_int_reason_ignore(rsn));
  gio_pin_model gio_pin_model_i (.i_out(out), .i_oe(oe), .i_board(brd),
    .o_pin(pin));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic complete_run;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e)
    begin
      miscompares++;
      $display("unexpected t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : idle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) req <= '{1'b1, 1'b0, a, d};
    @(posedge clk) req.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    int n;
    @(posedge clk) req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk) req.rd <= 1'b0;
    #1;
    n = 0;
    while (rsp.valid !== 1'b1 && n < 4)
    begin
      idle(1);
      n++;
    end
    if (n == 4)
    begin
      miscompares++;
      $display("unexpected t=%0t got %h exp %h", $time, rsp.valid, 1'b1);
      complete_run();
    end
    else
      chk(rsp.data, e);
  endtask : rd
  initial
  begin
    req = '0;
    rst_n = 1'b0;
    hs = 1'b0;
    irq = 1'b0;
    brd = 3'b101;
    miscompares = 0;
    checks_done = 0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    idle(8);
    chk({5'h00, oe}, 8'h00);
    rd(GIO_ADDR_IRQ_DIR, GIO_RST_IRQ_DIR);
    rd(GIO_ADDR_EVENT_PINS, 8'h05);
    wr(8'h0D, 8'h90);
    rd(8'h0D, GIO_RD_UNMAPPED);
    wr(GIO_ADDR_IRQ_DIR, 8'h08);
    rd(GIO_ADDR_IRQ_DIR, 8'h08);
    wr(GIO_ADDR_EVENT_PINS, 8'hA2);
    idle(6);
    chk({usr, out}, 8'hA2);
    chk({5'h00, oe}, 8'h07);
    rd(GIO_ADDR_EVENT_PINS, 8'hA2);
    wr(GIO_ADDR_IRQ_DIR, 8'h0B);
    idle(6);
    rd(GIO_ADDR_EVENT_PINS, 8'hA1);
    wr(GIO_ADDR_IRQ_DIR, 8'h18);
    for (int k = 0; k < 2; k++)
    begin
      @(posedge clk) hs <= k[0];
      idle(3);
      chk({7'h00, out[2]}, {7'h00, ~k[0]});
    end
    wr(GIO_ADDR_IRQ_DIR, 8'h1C);
    idle(3);
    chk({5'h00, oe}, 8'h03);
    @(posedge clk) irq <= 1'b1;
    wr(GIO_ADDR_IRQ_DIR, 8'h88);
    idle(3);
    chk({5'h00, pkt, rsn, irq_o}, 8'h04);
    wr(GIO_ADDR_IRQ_DIR, 8'h28);
    idle(3);
    chk({5'h00, pkt, rsn, irq_o}, 8'h03);
    wr(8'h10, 8'hFF);
    rd(GIO_ADDR_IRQ_DIR, 8'h28);
    @(posedge clk) rst_n <= 1'b0;
    idle(2);
    chk({usr, out}, 8'h00);
    chk({5'h00, oe}, 8'h00);
    @(posedge clk) rst_n <= 1'b1;
    idle(8);
    chk({5'h00, pkt, rsn, irq_o}, 8'h01);
    rd(GIO_ADDR_IRQ_DIR, GIO_RST_IRQ_DIR);
    rd(GIO_ADDR_EVENT_PINS, 8'h05);
    complete_run();
  end
endmodule : gio_option_config_bench
